// >>> hsc_regs.svh
// What this block does
// R1: A halt instruction enters standby from crystal or internal ring clock.
// R2: In standby the CPU clock is gated off.
// R3: Port output latches hold their entry value during standby.
// R4: On ring clock, timer H only guaranteed when counting timer A output.
// R5: On ring clock, real-time ports only guaranteed on pin trigger or counter B external.
// R6: On ring clock, clocked serial port only guaranteed on external serial clock.
// R7: Option byte picks permanent or stoppable ring oscillator; watchdog follows in halt.
// R8: Ring clock counts as stopped only if option allows and software stopped it.
// R9: Any unmasked interrupt request ends standby.
// R10: Release with interrupts enabled branches to the vectored service routine.
// R11: Release with interrupts disabled resumes after halt without servicing.
// R12: Release to vectored servicing takes 8 or 9 clocks.
// R13: Release to the next instruction takes 2 or 3 clocks.
// R14: A non-maskable request ends standby and always starts vectored servicing.
// R15: Reset during standby ends it and performs a normal reset.
// R16: An unmasked request already pending at halt leaves standby immediately.
// R17: Registers, flags and memory are preserved throughout standby.
// R18: Running oscillators keep oscillating during standby.
// R19: Wake latencies count cycles of the CPU clock source chosen at entry.
// R20: A masked request neither ends standby nor changes held state.
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
`define HSC_CTRL_OFS       12'h000
`define HSC_STAT_OFS       12'h004
`define HSC_CTRL_RING_STOP 0
`define HSC_CTRL_SRC_RING  1
`define HSC_CTRL_RST       2'h0
`define HSC_STAT_HALTED    0
`define HSC_STAT_RING_OFF  1
`define HSC_STAT_WDT_RUN   2
`define HSC_STAT_SRC_RING  3
`define HSC_STAT_LAST_VEC  4
`define HSC_STAT_LAST_RES  5
`define HSC_STAT_LAST_NMI  6
`define HSC_STAT_OPT_SW    7
`define HSC_VEC_WAIT       4'h8
`define HSC_NEXT_WAIT      4'h2
`endif

// >>> hsc_pkg.sv
`default_nettype none
package hsc_pkg;
  typedef enum logic [2:0] {
    HSC_RUN  = 3'b001,
    HSC_HALT = 3'b010,
    HSC_WAKE = 3'b100
  } hsc_state_t;

  typedef struct packed {
    logic tmrh_src_t8a;
    logic rtp_trig_pin;
    logic t8b_src_ext;
    logic csi_src_ext;
  } hsc_periph_cfg_t;

  typedef struct packed {
    logic tmrh_ok;
    logic rtp_ok;
    logic csi_ok;
    logic wdt_run;
  } hsc_periph_run_t;
endpackage
`default_nettype wire

// >>> hsc_halt_ctrl.sv
// Added by the designer: register access over APB and the address map.
`default_nettype none
`include "hsc_regs.svh"
module hsc_halt_ctrl
  import hsc_pkg::*;
#(
  parameter int NIRQ     = 8,
  parameter int IDW      = 3,
  parameter int RING_DIV = 4
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            opt_ring_sw_stoppable,
  input  wire logic            halt_exec,
  input  wire logic [NIRQ-1:0] irq_req,
  input  wire logic [NIRQ-1:0] irq_mask,
  input  wire logic            irq_enable,
  input  wire logic            nmi_req,
  input  wire hsc_periph_cfg_t periph_cfg,
  output logic                 cpu_clk_en,
  output logic                 port_hold,
  output logic                 xtal_osc_run,
  output logic                 ring_osc_run,
  output hsc_periph_run_t      periph_run,
  output logic                 wake_vector,
  output logic                 wake_resume,
  output logic                 wake_nmi,
  output logic [IDW-1:0]       wake_id
);

  typedef struct packed {
    hsc_state_t      state;
    logic [3:0]      cnt;
    logic            go_vec;
    logic            go_nmi;
    logic [IDW-1:0]  id;
    logic            src_ring;
    logic [1:0]      ctrl;
    logic            opt_sw;
    logic            opt_done;
    logic [7:0]      div;
    logic            cpu_clk_en;
    logic            port_hold;
    logic            xtal_run;
    logic            ring_run;
    hsc_periph_run_t prun;
    logic            wake_vec;
    logic            wake_res;
    logic            wake_nmi;
    logic [IDW-1:0]  wake_id;
    logic [2:0]      last;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } hsc_regs_t;

  hsc_regs_t s_r;
  hsc_regs_t s_nxt;

  function automatic logic [IDW-1:0] first_set(input logic [NIRQ-1:0] v);
    logic [IDW-1:0] r;
    r = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDW'(i);
      end
    end
    return r;
  endfunction

  logic [NIRQ-1:0] live_irq;
  logic            any_live;
  logic            src_tick;
  logic            ring_off;
  logic            apb_setup;
  logic            apb_wr;
  logic            halted;

  assign live_irq  = irq_req & ~irq_mask; // R9 R20
  assign any_live  = |live_irq;
  // Ring ticks come from a divider so that wake latency follows the slower source.
  assign src_tick  = s_r.src_ring ? (s_r.div == 8'(RING_DIV - 1)) : 1'b1; // R19
  assign ring_off  = s_r.opt_sw & s_r.ctrl[`HSC_CTRL_RING_STOP]; // R8
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & s_r.pready & pwrite;
  assign halted    = (s_r.state != HSC_RUN);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.wake_vec = 1'b0;
    s_nxt.wake_res = 1'b0;
    s_nxt.wake_nmi = 1'b0;

    // The option byte is sampled once after reset release, never under reset.
    if (!s_r.opt_done) begin
      s_nxt.opt_sw   = opt_ring_sw_stoppable; // R7
      s_nxt.opt_done = 1'b1;
    end

    if (s_r.src_ring) begin
      s_nxt.div = (s_r.div == 8'(RING_DIV - 1)) ? 8'h00 : s_r.div + 8'h01;
    end else begin
      s_nxt.div = 8'h00;
    end

    case (s_r.state)
      HSC_RUN: begin
        if (halt_exec) begin
          s_nxt.src_ring   = s_r.ctrl[`HSC_CTRL_SRC_RING]; // R1 R19
          s_nxt.div        = 8'h00;
          s_nxt.cpu_clk_en = 1'b0; // R2
          s_nxt.port_hold  = 1'b1; // R3 R17
          if (nmi_req || any_live) begin
            // A request pending at the halt instruction skips the standby wait.
            s_nxt.state  = HSC_WAKE; // R16
            s_nxt.go_nmi = nmi_req;
            s_nxt.go_vec = nmi_req | irq_enable;
            s_nxt.id     = first_set(live_irq);
            s_nxt.cnt    = (nmi_req | irq_enable) ? `HSC_VEC_WAIT : `HSC_NEXT_WAIT;
          end else begin
            s_nxt.state = HSC_HALT; // R1
          end
        end
      end
      HSC_HALT: begin
        if (nmi_req) begin
          s_nxt.state  = HSC_WAKE; // R14
          s_nxt.go_nmi = 1'b1;
          s_nxt.go_vec = 1'b1;
          s_nxt.cnt    = `HSC_VEC_WAIT; // R12
        end else if (any_live) begin
          s_nxt.state  = HSC_WAKE; // R9
          s_nxt.go_nmi = 1'b0;
          s_nxt.go_vec = irq_enable; // R10 R11
          s_nxt.id     = first_set(live_irq);
          s_nxt.cnt    = irq_enable ? `HSC_VEC_WAIT : `HSC_NEXT_WAIT; // R12 R13
        end
      end
      HSC_WAKE: begin
        if (src_tick) begin
          if (s_r.cnt == 4'h1) begin
            s_nxt.state      = HSC_RUN;
            s_nxt.cpu_clk_en = 1'b1;
            s_nxt.port_hold  = 1'b0;
            s_nxt.wake_vec   = s_r.go_vec; // R10 R14
            s_nxt.wake_res   = ~s_r.go_vec; // R11
            s_nxt.wake_nmi   = s_r.go_nmi;
            s_nxt.wake_id    = s_r.id;
            s_nxt.last       = {s_r.go_nmi, ~s_r.go_vec, s_r.go_vec};
          end else begin
            s_nxt.cnt = s_r.cnt - 4'h1; // R12 R13
          end
        end
      end
      default: begin
        s_nxt.state = HSC_RUN;
      end
    endcase

    // Peripheral limits apply only while halted from the ring clock.
    s_nxt.ring_run = ~ring_off; // R18
    s_nxt.xtal_run = 1'b1; // R18
    if (s_nxt.state != HSC_RUN && s_nxt.src_ring) begin
      s_nxt.prun.tmrh_ok = periph_cfg.tmrh_src_t8a; // R4
      s_nxt.prun.rtp_ok  = periph_cfg.rtp_trig_pin | periph_cfg.t8b_src_ext; // R5
      s_nxt.prun.csi_ok  = periph_cfg.csi_src_ext; // R6
    end else begin
      s_nxt.prun.tmrh_ok = 1'b1;
      s_nxt.prun.rtp_ok  = 1'b1;
      s_nxt.prun.csi_ok  = 1'b1;
    end
    s_nxt.prun.wdt_run = (s_nxt.state == HSC_RUN) | ~s_nxt.opt_sw; // R7

    // Every transfer gets one wait-free access phase after its setup cycle.
    s_nxt.pready  = apb_setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = 32'h0000_0000;
    if (apb_setup) begin
      if (paddr == `HSC_CTRL_OFS) begin
        s_nxt.prdata = {30'h0000_0000, s_r.ctrl};
      end else if (paddr == `HSC_STAT_OFS) begin
        s_nxt.prdata[`HSC_STAT_HALTED]   = halted;
        s_nxt.prdata[`HSC_STAT_RING_OFF] = ring_off;
        s_nxt.prdata[`HSC_STAT_WDT_RUN]  = s_r.prun.wdt_run;
        s_nxt.prdata[`HSC_STAT_SRC_RING] = s_r.src_ring;
        s_nxt.prdata[`HSC_STAT_LAST_VEC] = s_r.last[0];
        s_nxt.prdata[`HSC_STAT_LAST_RES] = s_r.last[1];
        s_nxt.prdata[`HSC_STAT_LAST_NMI] = s_r.last[2];
        s_nxt.prdata[`HSC_STAT_OPT_SW]   = s_r.opt_sw;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (apb_wr && paddr == `HSC_CTRL_OFS) begin
      s_nxt.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Reset drops any standby and restarts the CPU from its reset vector.
      s_r            <= '0; // R15
      s_r.state      <= HSC_RUN;
      s_r.ctrl       <= `HSC_CTRL_RST;
      s_r.cpu_clk_en <= 1'b1;
      s_r.ring_run   <= 1'b1;
      s_r.xtal_run   <= 1'b1;
      s_r.prun       <= 4'hf;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign cpu_clk_en   = s_r.cpu_clk_en;
  assign port_hold    = s_r.port_hold;
  // No stop mode lives in this block, so the crystal is never stopped.
  assign xtal_osc_run = s_r.xtal_run; // R18
  assign ring_osc_run = s_r.ring_run;
  assign periph_run   = s_r.prun;
  assign wake_vector  = s_r.wake_vec;
  assign wake_resume  = s_r.wake_res;
  assign wake_nmi     = s_r.wake_nmi;
  assign wake_id      = s_r.wake_id;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_halt_entry: assert property ( // R1
    s_r.state == HSC_RUN && halt_exec && !nmi_req && !any_live |=> s_r.state == HSC_HALT)
    else $error("halt instruction did not enter standby");
  chk_clk_gated: assert property ( // R2
    halted |-> !cpu_clk_en) else $error("cpu clock running in standby");
  chk_port_held: assert property ( // R3
    s_r.state == HSC_HALT |-> port_hold) else $error("port latch not held");
  chk_masked_stay: assert property ( // R20
    s_r.state == HSC_HALT && !nmi_req && !any_live |=> s_r.state == HSC_HALT)
    else $error("masked request left standby");
  // Exact latencies are checked for the crystal source; ring vectored wakes get a lower bound, and NMI wakes an upper bound of 300.
  chk_vec_latency: assert property ( // R12
    s_r.state == HSC_HALT && (nmi_req || (any_live && irq_enable)) && !s_r.src_ring
      |=> !wake_vector [*8] ##1 wake_vector) else $error("vectored wake not after 8 clocks");
  chk_next_latency: assert property ( // R13
    s_r.state == HSC_HALT && !nmi_req && any_live && !irq_enable && !s_r.src_ring
      |=> ##2 wake_resume) else $error("resume wake not after 2 clocks");
  chk_ring_slower: assert property ( // R19
    s_r.state == HSC_HALT && s_r.src_ring && (nmi_req || any_live) |=> !wake_vector [*8])
    else $error("ring wake faster than crystal");
  chk_nmi_vector: assert property ( // R14
    s_r.state == HSC_HALT && nmi_req |-> ##[1:300] wake_vector && wake_nmi)
    else $error("nmi did not vector");
  chk_nmi_first: assert property ( // R14
    s_r.state == HSC_HALT && nmi_req |=> s_r.go_nmi && s_r.go_vec) else $error("nmi cause not latched");
  chk_nmi_flag: assert property ( // R14
    wake_nmi |-> wake_vector) else $error("nmi wake without vector");
  chk_resume_plain: assert property ( // R11
    wake_resume |-> !wake_vector && !wake_nmi) else $error("resume wake also vectored");
  chk_wake_exit: assert property ( // R10
    wake_vector || wake_resume |-> cpu_clk_en && !port_hold && !halted) else $error("wake left cpu halted");
  chk_pending_skip: assert property ( // R16
    s_r.state == HSC_RUN && halt_exec && any_live |=> s_r.state == HSC_WAKE)
    else $error("pending request did not skip standby");
  chk_wdt_stop: assert property ( // R7
    halted && s_r.opt_sw |-> !periph_run.wdt_run) else $error("watchdog ran in halt");
  chk_wdt_kept: assert property ( // R7
    !s_r.opt_sw |-> periph_run.wdt_run) else $error("fixed ring stopped the watchdog");
  chk_ring_kept: assert property ( // R8
    !s_r.opt_sw |-> ring_osc_run) else $error("fixed ring oscillator stopped");
  chk_ring_limit: assert property ( // R4
    halted && s_r.src_ring && $past(halted) |-> periph_run.tmrh_ok == periph_cfg.tmrh_src_t8a
      || $changed(periph_cfg)) else $error("timer H limit wrong");
  chk_rtp_limit: assert property ( // R5
    halted && s_r.src_ring
      |-> periph_run.rtp_ok == ($past(periph_cfg.rtp_trig_pin) || $past(periph_cfg.t8b_src_ext)))
    else $error("real-time port limit wrong");
  chk_csi_limit: assert property ( // R6
    halted && s_r.src_ring |-> periph_run.csi_ok == $past(periph_cfg.csi_src_ext))
    else $error("serial port limit wrong");

  // The bus side never stretches a transfer, so ready is a single-cycle pulse.
  chk_pready_pulse: assert property (
    pready |=> !pready) else $error("ready held two cycles");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");

  cov_wake_vec: cover property (s_r.state == HSC_WAKE ##[1:300] wake_vector);
  cov_wake_res: cover property (s_r.state == HSC_WAKE ##[1:300] wake_resume);
  cov_ring_halt: cover property (s_r.state == HSC_HALT && s_r.src_ring);
  cov_nmi_wake: cover property (wake_vector && wake_nmi);
  cov_pending: cover property (s_r.state == HSC_RUN && halt_exec && any_live);
endmodule // hsc_halt_ctrl
`default_nettype wire

// >>> hsc_cpu_model.sv
`default_nettype none
module hsc_cpu_model #(
  parameter int NIRQ = 8
) (
  input  wire logic            clk_sys,
  input  wire logic            wake_vector,
  input  wire logic            wake_resume,
  output var  logic            halt_exec,
  output var  logic [NIRQ-1:0] irq_req,
  output var  logic [NIRQ-1:0] irq_mask,
  output var  logic            irq_enable,
  output var  logic            nmi_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    halt_exec  = 1'b0;
    irq_req    = '0;
    irq_mask   = '0;
    irq_enable = 1'b0;
    nmi_req    = 1'b0;
  end

  // The halt instruction is a single-cycle pulse, raised at the call edge and dropped one clock later.
  task automatic halt();
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
  endtask

  task automatic post(input logic [NIRQ-1:0] r, input logic [NIRQ-1:0] m, input logic ie, input logic nmi);
    irq_req    <= r;
    irq_mask   <= m;
    irq_enable <= ie;
    nmi_req    <= nmi;
  endtask

  // Servicing or resuming acknowledges the request, so the flags drop after a wake pulse.
  always @(posedge clk_sys) begin
    if (wake_vector | wake_resume) begin
      irq_req <= '0;
      nmi_req <= 1'b0;
    end
  end
endmodule // hsc_cpu_model
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
  import hsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RD = 2;
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  logic            opt_sw = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata, q;
  logic            pready, pslverr, e, halt_exec, irq_enable, nmi_req, cpu_clk_en, port_hold;
  logic            xtal_osc_run, ring_osc_run, wake_vector, wake_resume, wake_nmi;
  logic [7:0]      irq_req, irq_mask;
  logic [2:0]      wake_id;
  hsc_periph_cfg_t periph_cfg = 4'ha;
  hsc_periph_run_t periph_run;
  int              bad_count = 0;
  int              n_tests = 0;
  int              n;

  always #25 clk_sys = ~clk_sys;

  hsc_halt_ctrl #(.RING_DIV(RD)) u_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .opt_ring_sw_stoppable(opt_sw), .halt_exec, .irq_req, .irq_mask,
    .irq_enable, .nmi_req, .periph_cfg, .cpu_clk_en, .port_hold, .xtal_osc_run, .ring_osc_run,
    .periph_run, .wake_vector, .wake_resume, .wake_nmi, .wake_id);
  hsc_cpu_model u_cpu (.clk_sys, .wake_vector, .wake_resume, .halt_exec, .irq_req, .irq_mask,
    .irq_enable, .nmi_req);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from re-driving the strobes in this time step.
    @(posedge clk_sys);
  endtask

  // Counts edges from the call edge until a wake pulse is sampled.
  task automatic wake_wait();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((wake_vector | wake_resume) !== 1'b1 && n < 100);
  endtask

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("reset outputs", 32'hbf, {cpu_clk_en, port_hold, xtal_osc_run, ring_osc_run, periph_run});
    apb(1'b0, 12'h004, 32'h0);
    chk("stat option", 32'h80, q & 32'h81);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset and registers done");
    u_cpu.post(8'h02, 8'h02, 1'b1, 1'b0);
    u_cpu.halt();
    repeat (20) @(posedge clk_sys);
    chk("masked held", 32'h1, {cpu_clk_en, port_hold});
    u_cpu.post(8'h22, 8'h02, 1'b1, 1'b0);
    wake_wait();
    chk("vector edges", 32'd10, n);
    chk("vector flags", 32'h4, {wake_vector, wake_resume, wake_nmi});
    chk("wake id", 32'h5, wake_id);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      u_cpu.halt();
      repeat (3) @(posedge clk_sys);
      u_cpu.post(k ? 8'h00 : 8'h01, 8'h00, 1'b0, k[0]);
      wake_wait();
      chk("wake edges", k ? 32'd10 : 32'd4, n);
      chk("wake flags", k ? 32'h5 : 32'h2, {wake_vector, wake_resume, wake_nmi});
    end
    @(posedge clk_sys);
    u_cpu.post(8'h08, 8'h00, 1'b1, 1'b0);
    u_cpu.halt();
    wake_wait();
    chk("pending edges", 32'd9, n);
    $display("test crystal wake done");
    apb(1'b1, 12'h000, 32'h2);
    for (int k = 0; k < 2; k++) begin
      periph_cfg <= k ? 4'h5 : 4'ha;
      u_cpu.post(8'h00, 8'h00, 1'b1, 1'b0);
      u_cpu.halt();
      @(posedge clk_sys);
      chk("ring periph", k ? 32'h6 : 32'hc, periph_run);
      u_cpu.post(8'h01, 8'h00, 1'b1, 1'b0);
      wake_wait();
      chk("ring latency", 32'h1, {31'h0, n >= 8 * RD + 1 && n <= 9 * RD + 2});
      @(posedge clk_sys);
    end
    apb(1'b1, 12'h000, 32'h1);
    @(posedge clk_sys);
    chk("ring stopped", 32'h0, ring_osc_run);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat ring off", 32'h2, q & 32'h2);
    apb(1'b1, 12'h000, 32'h0);
    $display("test ring source done");
    u_cpu.halt();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    opt_sw <= 1'b0;
    @(posedge clk_sys);
    chk("reset in halt", 32'h2, {cpu_clk_en, port_hold});
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    apb(1'b1, 12'h000, 32'h1);
    u_cpu.halt();
    @(posedge clk_sys);
    chk("fixed ring in halt", 32'h1f, {ring_osc_run, periph_run});
    $display("test reset in halt done");
    summarize();
  end
endmodule // tb
`default_nettype wire
